// ==== core/pcsq_pkg.sv ====
// Package with constants and types for the program sequencing block
`default_nettype none
package pcsq_pkg;
	localparam int PCSQ_PC_W = 12;
	localparam int PCSQ_WORD_W = 16;
	localparam int PCSQ_DEPTH = 8;
	localparam int PCSQ_SP_W = 3;
	localparam logic [8:0] PCSQ_OFS_LOW = 9'h002;
	localparam logic [8:0] PCSQ_OFS_LATCH = 9'h00a;
	localparam logic [8:0] PCSQ_OFS_VIEW = 9'h10c;
	localparam logic [8:0] PCSQ_OFS_TPORT = 9'h18c;
	localparam logic [6:0] PCSQ_BANK_MASK = 7'h7f;
	localparam logic [11:0] PCSQ_RESET_VEC = 12'h000;
	localparam logic [11:0] PCSQ_INT_VEC = 12'h004;
	localparam logic [7:0] PCSQ_KEEP_CODE = 8'h1c;
	localparam logic [7:0] PCSQ_TP_LOW_CODE = 8'h01;
	localparam logic [7:0] PCSQ_TP_HIGH_CODE = 8'h02;
	localparam logic [7:0] PCSQ_REG_RESET = 8'h00;
	localparam int PCSQ_SEL_BIT = 3;
	localparam int PCSQ_SHORT_W = 11;
	typedef enum logic [7:0] {
		PCSQ_OP_NONE = 8'h01,
		PCSQ_OP_STEP = 8'h02,
		PCSQ_OP_SJUMP = 8'h04,
		PCSQ_OP_SCALL = 8'h08,
		PCSQ_OP_LJUMP = 8'h10,
		PCSQ_OP_LONG_SUBROUTINE_ENTRY = 8'h20,
		PCSQ_OP_RET = 8'h40,
		PCSQ_OP_INT = 8'h80
	} pcsq_op_t;
endpackage
`default_nettype wire

// ==== core/pcsq_stack_if.sv ====
// Interface between the sequencer and its return stack
`default_nettype none
interface pcsq_stack_if;
	logic push;
	logic pop;
	logic [11:0] push_addr;
	logic [11:0] top_addr;
	modport seq (output push, output pop, output push_addr, input top_addr);
	modport stk (input push, input pop, input push_addr, output top_addr);
endinterface
`default_nettype wire

// ==== core/pcsq_stack.sv ====
// Eight-entry return address stack
`default_nettype none
module pcsq_stack
	import pcsq_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	pcsq_stack_if.stk st
);
	logic [PCSQ_SP_W-1:0] sp_q;
	logic [PCSQ_SP_W-1:0] sp_d;
	logic [PCSQ_SP_W-1:0] top_idx;
	logic [PCSQ_PC_W-1:0] mem_q [PCSQ_DEPTH];

	// Pointer wraps silently, so a ninth push reuses the oldest slot
	assign top_idx = sp_q - 3'd1;
	assign sp_d = st.push ? sp_q + 3'd1 : (st.pop ? top_idx : sp_q);
	assign st.top_addr = mem_q[top_idx];

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sp_q <= '0;
		end else begin
			sp_q <= sp_d;
		end
	end

	genvar i;
	generate
		for (i = 0; i < PCSQ_DEPTH; i++) begin : g_ent
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					mem_q[i] <= PCSQ_RESET_VEC;
				end else if (st.push && sp_q == PCSQ_SP_W'(i)) begin
					mem_q[i] <= st.push_addr;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ==== core/pcsq_top.sv ====
// Program counter, return stack and table fetch sequencing
// Function
// - Twelve-bit counter over 4K x 16 memory
// - Counter steps by one otherwise
// - Reset vector 000h, interrupt vector 004h
// - Short branch: 11 bits plus latch bit 3
// - All returns reload counter from stack top
// - Long branches reach all; latch bit 3 zero
// - Low byte register mirrored in every bank
// - High view reads bits 11:8, read only
// - Writing 1Ch sets keep flag, others clear
// - Keep clear: low write loads latch high
// - Keep set: low write keeps high bits
// - Stack holds eight twelve-bit entries
// - Long call, short call and interrupt push; returns pop
// - Table instructions fetch word via pointer
// - Port write 01h fetches low byte
// - Port write 02h fetches high byte
// - Port reads last fetched or plainly stored byte
// - Any reset clears counter to zero
`default_nettype none
module pcsq_top
	import pcsq_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic step_en,
	input wire pcsq_pkg::pcsq_op_t op,
	input wire logic [10:0] short_target,
	input wire logic [11:0] long_target,
	input wire logic tab_low_inst,
	input wire logic tab_high_inst,
	input wire logic [7:0] table_pointer_high,
	input wire logic [7:0] table_pointer_low,
	input wire logic [8:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	output logic [11:0] prog_addr,
	output logic [11:0] fetch_addr,
	input wire logic [15:0] prog_word,
	output logic [7:0] w_wdata,
	output logic w_we
);
	import pcsq_pkg::*;

	pcsq_stack_if st ();

	logic [11:0] pc_q;
	logic [11:0] pc_d;

	logic [7:0] latch_q;
	logic keep_high_flag_q;
	logic [7:0] tport_q;

	logic [7:0] rdata_q;
	logic hit_q;
	logic [7:0] wdat_q;
	logic we_q;

	// Table fetch walks idle, address out, byte delivered
	typedef enum logic [2:0] {
		PCSQ_FS_IDLE = 3'b001,
		PCSQ_FS_ADDR = 3'b010,
		PCSQ_FS_DELIVER = 3'b100
	} pcsq_fstate_t;

	pcsq_fstate_t fs_q;
	pcsq_fstate_t fs_d;
	logic tab_pend;
	logic tab_hi_q;
	logic [11:0] fa_q;

	// Low byte mirrors ignore the bank bits
	wire hit_low = (reg_addr[6:0] & PCSQ_BANK_MASK) == PCSQ_OFS_LOW[6:0];
	wire hit_latch = (reg_addr[6:0] & PCSQ_BANK_MASK) == PCSQ_OFS_LATCH[6:0];

	// High view and table port exist in one bank only
	wire hit_view = reg_addr == PCSQ_OFS_VIEW;
	wire hit_tport = reg_addr == PCSQ_OFS_TPORT;
	wire any_hit = hit_low | hit_latch | hit_view | hit_tport;

	wire wr_low = reg_wr && hit_low;
	wire wr_view = reg_wr && hit_view;
	wire wr_tport = reg_wr && hit_tport;

	wire tp_low = wr_tport && reg_wdata == PCSQ_TP_LOW_CODE;
	wire tp_high = wr_tport && reg_wdata == PCSQ_TP_HIGH_CODE;
	wire tab_start = tab_low_inst | tab_high_inst | tp_low | tp_high;
	wire tab_hi_sel = tab_high_inst | tp_high;

	wire [11:0] next_seq = pc_q + 12'h001;
	wire [11:0] short_addr = {latch_q[PCSQ_SEL_BIT], short_target};
	wire [11:0] low_write_addr = keep_high_flag_q ? {pc_q[11:8], reg_wdata}
		: {latch_q[3:0], reg_wdata};
	wire [7:0] fetched = tab_hi_q ? prog_word[15:8] : prog_word[7:0];
	wire [7:0] rd_mux = hit_low ? pc_q[7:0]
		: hit_latch ? latch_q
		: hit_view ? {4'h0, pc_q[11:8]}
		: hit_tport ? tport_q
		: 8'h00;

	// Long call pushes the next address; interrupt pushes the address it preempts
	assign st.push = step_en && (op == PCSQ_OP_LONG_SUBROUTINE_ENTRY || op == PCSQ_OP_SCALL || op == PCSQ_OP_INT);
	assign st.pop = step_en && op == PCSQ_OP_RET;
	assign st.push_addr = op == PCSQ_OP_INT ? pc_q : next_seq;

	// A low-byte write outranks the plain step of its own instruction
	always_comb begin
		pc_d = pc_q;
		if (step_en) begin
			case (op)
				PCSQ_OP_STEP: pc_d = wr_low ? low_write_addr : next_seq;
				PCSQ_OP_SJUMP: pc_d = short_addr;
				PCSQ_OP_SCALL: pc_d = short_addr;
				PCSQ_OP_LJUMP: pc_d = long_target;
				PCSQ_OP_LONG_SUBROUTINE_ENTRY: pc_d = long_target;
				PCSQ_OP_RET: pc_d = st.top_addr;
				PCSQ_OP_INT: pc_d = PCSQ_INT_VEC;
				PCSQ_OP_NONE: pc_d = pc_q;
				default: pc_d = pc_q;
			endcase
		end else if (wr_low) begin
			pc_d = low_write_addr;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pc_q <= PCSQ_RESET_VEC;
		end else begin
			pc_q <= pc_d;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			latch_q <= PCSQ_REG_RESET;
		end else if (reg_wr && hit_latch) begin
			latch_q <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			keep_high_flag_q <= 1'b0;
		end else if (wr_view) begin
			keep_high_flag_q <= reg_wdata == PCSQ_KEEP_CODE;
		end
	end

	// Fetch takes one cycle: address goes out, word returns next edge
	// A new trigger in any state restarts the fetch, so back-to-back reads work
	always_comb begin
		fs_d = fs_q;
		case (fs_q)
			PCSQ_FS_IDLE: begin
				if (tab_start) begin
					fs_d = PCSQ_FS_ADDR;
				end
			end
			PCSQ_FS_ADDR: begin
				fs_d = tab_start ? PCSQ_FS_ADDR : PCSQ_FS_DELIVER;
			end
			PCSQ_FS_DELIVER: begin
				fs_d = tab_start ? PCSQ_FS_ADDR : PCSQ_FS_IDLE;
			end
			default: begin
				fs_d = PCSQ_FS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fs_q <= PCSQ_FS_IDLE;
		end else begin
			fs_q <= fs_d;
		end
	end

	assign tab_pend = fs_q == PCSQ_FS_ADDR;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tab_hi_q <= 1'b0;
		end else if (tab_start) begin
			tab_hi_q <= tab_hi_sel;
		end
	end

	// Pointer bits beyond the counter width are dropped
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fa_q <= PCSQ_RESET_VEC;
		end else if (tab_start) begin
			fa_q <= {table_pointer_high[3:0], table_pointer_low};
		end
	end

	// The fetched byte outranks a plain store in the same cycle
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tport_q <= PCSQ_REG_RESET;
		end else if (tab_pend) begin
			tport_q <= fetched;
		end else if (wr_tport) begin
			tport_q <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			we_q <= 1'b0;
		end else begin
			we_q <= tab_pend;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wdat_q <= 8'h00;
		end else if (tab_pend) begin
			wdat_q <= fetched;
		end
	end

	// Read data is registered, so it answers one cycle after the address
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= any_hit;
		end
	end

	assign prog_addr = pc_q;
	assign fetch_addr = fa_q;
	assign w_wdata = wdat_q;
	assign w_we = we_q;
	assign reg_rdata = rdata_q;
	assign reg_hit = hit_q;

	pcsq_stack u_stack (
		.clock(clock),
		.nrst(nrst),
		.st(st)
	);
endmodule
`default_nettype wire

// ==== tb/pcsq_mem.sv ====
// Program memory model answering table fetches
`default_nettype none
module pcsq_mem (
	input wire logic [11:0] fetch_addr,
	output logic [15:0] prog_word
);
	// Every address bit lands in the word, so a wrong pointer bit shows
	assign prog_word = {fetch_addr[7:0] ^ 8'ha5, fetch_addr[11:4]};
endmodule
`default_nettype wire

// ==== tb/pcsq_sva.sv ====
// Port assertions for the program sequencing block
`default_nettype none
module pcsq_sva
	import pcsq_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic step_en,
	input wire pcsq_pkg::pcsq_op_t op,
	input wire logic [10:0] short_target,
	input wire logic [11:0] long_target,
	input wire logic [8:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_hit,
	input wire logic [11:0] prog_addr
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Idle cycles keep the counter still, so reads can be tied to it
	wire logic idle = !step_en && !reg_wr;
	wire logic low = reg_addr[6:0] == PCSQ_OFS_LOW[6:0];
	AST_STEP: assert property (step_en && op == PCSQ_OP_STEP && !reg_wr |=> prog_addr == $past(prog_addr) + 12'h001)
		else $error("no step");
	AST_HOLD: assert property (idle |=> $stable(prog_addr))
		else $error("counter moved");
	AST_LJMP: assert property (step_en && op == PCSQ_OP_LJUMP |=> prog_addr == $past(long_target))
		else $error("long jump");
	AST_SJMP: assert property (step_en && op == PCSQ_OP_SJUMP |=> prog_addr[10:0] == $past(short_target))
		else $error("short jump");
	AST_INT: assert property (step_en && op == PCSQ_OP_INT |=> prog_addr == PCSQ_INT_VEC)
		else $error("int vector");
	AST_LOWWR: assert property (reg_wr && low && !step_en |=> prog_addr[7:0] == $past(reg_wdata))
		else $error("low write");
	AST_VIEW: assert property (reg_addr == PCSQ_OFS_VIEW && idle |=> reg_rdata == {4'h0, prog_addr[11:8]})
		else $error("high view");
	AST_LOWRD: assert property (low && idle |=> reg_rdata == prog_addr[7:0] && reg_hit)
		else $error("low read");
	AST_RST: assert property ($rose(nrst) |-> prog_addr == PCSQ_RESET_VEC)
		else $error("reset vector");
	COV_RET: cover property (step_en && op == PCSQ_OP_RET);
	COV_INT: cover property (step_en && op == PCSQ_OP_INT);
	COV_TP: cover property (reg_wr && reg_addr == PCSQ_OFS_TPORT);
endmodule
bind pcsq_top pcsq_sva i_pcsq_sva (.clock, .nrst, .step_en, .op, .short_target, .long_target, .reg_addr,
	.reg_wr, .reg_wdata, .reg_rdata, .reg_hit, .prog_addr);
`default_nettype wire

// ==== tb/pcsq_top_tb.sv ====
// Self-checking bench for the program sequencing block
`default_nettype none
module pcsq_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pcsq_pkg::*;
	logic clock = 0, nrst = 0, step_en = 0, tab_low_inst = 0, tab_high_inst = 0, reg_wr = 0, rd_v = 0;
	logic w_we, reg_hit;
	pcsq_op_t op = PCSQ_OP_NONE;
	logic [10:0] short_target = 0;
	logic [11:0] long_target = 0, prog_addr, fetch_addr, t;
	logic [7:0] table_pointer_high = 0, table_pointer_low = 0, reg_wdata = 0, reg_rdata, w_wdata, d, e;
	logic [8:0] reg_addr = 0;
	logic [8:0] ra[5] = '{PCSQ_OFS_LOW, PCSQ_OFS_LATCH, PCSQ_OFS_VIEW, PCSQ_OFS_TPORT, 9'h005};
	logic [15:0] prog_word, w;
	logic [7:0] exq[$];
	int fails = 0, checks_done = 0;
	always #4 clock = ~clock;
	pcsq_top i_pcsq_top (.clock, .nrst, .step_en, .op, .short_target, .long_target, .tab_low_inst,
		.tab_high_inst, .table_pointer_high, .table_pointer_low, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rdata, .reg_hit, .prog_addr, .fetch_addr, .prog_word, .w_wdata, .w_we);
	pcsq_mem i_pcsq_mem (.fetch_addr, .prog_word);
	function automatic logic [15:0] mw(logic [11:0] a);
		return {a[7:0] ^ 8'ha5, a[11:4]};
	endfunction
	task automatic cmp(logic [11:0] got, logic [11:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic go(pcsq_op_t o, logic [11:0] tg, logic [11:0] ex);
		@(posedge clock);
		step_en <= 1;
		op <= o;
		long_target <= tg;
		short_target <= tg[10:0];
		@(posedge clock);
		step_en <= 0;
		#1 cmp(prog_addr, ex);
	endtask
	task automatic wr(logic [8:0] a, logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1;
		@(posedge clock);
		reg_wr <= 0;
	endtask
	// Read data is looked at on the falling edge, clear of the flop updates
	task automatic rd(logic [8:0] a, logic [7:0] ex);
		@(posedge clock);
		reg_addr <= a;
		exq.push_back(ex);
		@(posedge clock);
		rd_v <= 1;
		@(posedge clock);
		rd_v <= 0;
	endtask
	task automatic tf(bit h, bit p);
		@(posedge clock);
		w = mw({table_pointer_high[3:0], table_pointer_low});
		if (p) begin
			reg_addr <= PCSQ_OFS_TPORT;
			reg_wdata <= h ? PCSQ_TP_HIGH_CODE : PCSQ_TP_LOW_CODE;
			reg_wr <= 1;
		end else if (h) tab_high_inst <= 1;
		else tab_low_inst <= 1;
		exq.push_back(h ? w[15:8] : w[7:0]);
		@(posedge clock);
		reg_wr <= 0;
		tab_high_inst <= 0;
		tab_low_inst <= 0;
		#1 cmp(fetch_addr, {table_pointer_high[3:0], table_pointer_low});
		repeat (3) @(posedge clock);
		if (p) rd(PCSQ_OFS_TPORT, h ? w[15:8] : w[7:0]);
	endtask
	always @(negedge clock)
		if (w_we === 1'b1 || rd_v) cmp(w_we === 1'b1 ? w_wdata : reg_rdata, exq.pop_front());
	initial begin
		#100000;
		fails++;
		close_out;
	end
	initial begin
		void'($urandom(32'h9e2f_3243));
		repeat (4) @(posedge clock);
		nrst <= 1;
		#1 cmp(prog_addr, PCSQ_RESET_VEC);
		foreach (ra[i]) rd(ra[i], PCSQ_REG_RESET);
		$display("done reset");
		t = $urandom;
		go(PCSQ_OP_STEP, 0, 12'h001);
		go(PCSQ_OP_LJUMP, t, t);
		go(PCSQ_OP_LONG_SUBROUTINE_ENTRY, t ^ 12'h0f0, t ^ 12'h0f0);
		go(PCSQ_OP_INT, 0, PCSQ_INT_VEC);
		go(PCSQ_OP_RET, 0, t ^ 12'h0f0);
		go(PCSQ_OP_RET, 0, t + 12'h001);
		// Bit 3 ends clear so later long jumps follow the software rule
		for (int b = 1; b >= 0; b--) begin
			d = $urandom;
			d[3] = b[0];
			wr(9'h08a, d);
			go(PCSQ_OP_SJUMP, t, {b[0], t[10:0]});
			rd(PCSQ_OFS_LATCH, d);
		end
		$display("done branch");
		e = $urandom;
		wr(PCSQ_OFS_LOW, e);
		#1 cmp(prog_addr, {d[3:0], e});
		go(PCSQ_OP_LJUMP, t, t);
		wr(PCSQ_OFS_VIEW, PCSQ_KEEP_CODE);
		wr(9'h182, ~e);
		#1 cmp(prog_addr, {t[11:8], ~e});
		rd(PCSQ_OFS_VIEW, {4'h0, t[11:8]});
		rd(9'h102, ~e);
		wr(PCSQ_OFS_VIEW, 8'h1d);
		wr(9'h082, e);
		#1 cmp(prog_addr, {d[3:0], e});
		$display("done low byte");
		for (int i = 0; i < 9; i++) go(PCSQ_OP_LONG_SUBROUTINE_ENTRY, 12'(i * 16), 12'(i * 16));
		for (int i = 7; i >= 0; i--) go(PCSQ_OP_RET, 0, 12'(i * 16 + 1));
		$display("done stack");
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			table_pointer_high <= $urandom;
			table_pointer_low <= $urandom;
			tf(i[0], i[1]);
		end
		$display("done table");
		close_out;
	end
endmodule
`default_nettype wire
